//--- tec_cfg.svh
// Constants of the 16-bit interval timer and event counter
// Functional notes
// - Mode bits 11 start count-up, clear on compare A
// - Match on compare A clears count, raises irq
// - Compare A value M gives M+1 clock interval
// - Compare B match always raises its irq
// - Output control 03H toggles wave each A match
// - Event edge clock select counts valid event edges
// - Event mode: first irq M+2 edges, then M+1
// - Event edge accepted after two equal samples
// - Count read returns value without disturbing counting
// - Switch bit 1 picks event pin or serial receive
// - Switch bit 0 picks interrupt pin or serial receive
// - Switch bits 5:4 choose serial pin pair
// - Switch bit 3 enables port-11 serial receive
// - Switch bit 2 gates aux timer input by PWM
// - Switch register resets 00H, bits 7:6 zero
// - Port 3 direction resets FFH, fixed bits one
// - Toggle enable gates wave toggle, irq still raised
`ifndef TEC_CFG_SVH
`define TEC_CFG_SVH

`define TEC_ADDR_W        18
`define TEC_IDX_PORT3_DIR 16'hFF23
`define TEC_IDX_ISC       16'hFF4F
`define TEC_IDX_MODE      16'hFF00
`define TEC_IDX_PRESCALE  16'hFF01
`define TEC_IDX_OUTCTL    16'hFF02
`define TEC_IDX_CMP_A     16'hFF04
`define TEC_IDX_CMP_B     16'hFF05
`define TEC_IDX_COUNT     16'hFF06

`define TEC_RST_PORT3_DIR 8'hFF
`define TEC_DIR_FIXED     8'hE1
`define TEC_RST_ISC       8'h00
`define TEC_ISC_MASK      8'h3F
`define TEC_RST_CMP       16'hFFFF

`define TEC_MODE_RUN      2'h3
`define TEC_MODE_STOP     2'h0
`define TEC_CLK_EVENT     2'h3

`define TEC_OC_ENABLE     0
`define TEC_OC_TOGGLE_A   1
`define TEC_OC_LVL_CLR    2
`define TEC_OC_LVL_SET    3
`define TEC_OC_TOGGLE_B   4

`define TEC_ISC_EXT0_SEL  0
`define TEC_ISC_EVT_SEL   1
`define TEC_ISC_AUX_GATE  2
`define TEC_ISC_RX11_EN   3
`define TEC_ISC_PIN_LO    4
`define TEC_ISC_PIN_HI    5

`define TEC_PS_EDGE_LO    4
`define TEC_PS_EDGE_HI    5

`define TEC_RESP_OKAY     2'h0
`define TEC_RESP_SLVERR   2'h2

`endif

//--- tec_pkg.sv
// Types shared by the timer and event counter
package tec_pkg;

  typedef enum logic [3:0] {
    TEC_R_NONE, TEC_R_DIR, TEC_R_ISC, TEC_R_MODE, TEC_R_PRESCALE,
    TEC_R_OUTCTL, TEC_R_CMP_A, TEC_R_CMP_B, TEC_R_COUNT
  } tec_reg_t;

  typedef struct packed {
    logic port3_bit3;
    logic port3_bit4;
    logic port11_bit3;
    logic port1_bit2;
    logic pin_ext_interrupt0;
    logic aux_pwm_output;
    logic serial6_transmit;
  } tec_pins_in_t;

  typedef struct packed {
    logic port11_bit2;
    logic port1_bit3;
    logic ext_interrupt0;
    logic aux_timer_input;
  } tec_route_out_t;

endpackage : tec_pkg

//--- tec_prescaler.sv
// Count clock divider for the timer
`timescale 1ns/1ps
module tec_prescaler #(
  parameter int DIV_W = 2
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       clear,
  input  wire logic [1:0] sel,
  output logic            tick
);
  logic [DIV_W-1:0] div_r;

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // Select 3 is the event edge; the top ignores this tick then
  always_comb begin
    case (sel)
      2'h0:    tick = 1'b1;
      2'h1:    tick = div_r[0];
      default: tick = &div_r[1:0];
    endcase
  end
endmodule : tec_prescaler

//--- tec_edge_filter.sv
// Noise filter and valid edge detector for the event input
`timescale 1ns/1ps
module tec_edge_filter (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       din,
  input  wire logic [1:0] edge_sel,
  output logic            edge_pulse
);
  logic samp_r;
  logic level_r;
  logic accept;

  // Level only moves after two equal samples, so one-cycle glitches die
  assign accept = (din == samp_r) && (din != level_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      samp_r  <= 1'b0;
      level_r <= 1'b0;
    end else begin
      samp_r <= din;
      if (accept) begin
        level_r <= din;
      end
    end
  end

  always_comb begin
    case (edge_sel)
      2'h0:    edge_pulse = accept && !din;
      2'h1:    edge_pulse = accept && din;
      2'h3:    edge_pulse = accept;
      default: edge_pulse = 1'b0;
    endcase
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Level may only move to a value the pin held on the two previous samples
  a_filter_two_samples: assert property ($past(aresetn) && level_r != $past(level_r)
                                         |-> $past(din) == $past(din, 2) && level_r == $past(din))
    else $error("Edge accepted without two equal samples");
endmodule : tec_edge_filter

//--- tec_timer16.sv
// Top of the 16-bit interval timer and event counter with AXI4-Lite registers
`timescale 1ns/1ps
`include "tec_cfg.svh"
module tec_timer16
  import tec_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`TEC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`TEC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire tec_pins_in_t           pins_in,
  output tec_route_out_t              route_out,
  output logic                        match_a_irq,
  output logic                        match_b_irq,
  output logic                        wave_output,
  output logic                        port3_bit4_oe,
  output logic [7:0]                  port3_dir_reg
);

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  function automatic tec_reg_t decode(input logic [`TEC_ADDR_W-1:0] a);
    logic [15:0] idx;
    idx = a[`TEC_ADDR_W-1:2];
    if (idx == `TEC_IDX_PORT3_DIR) begin
      decode = TEC_R_DIR;
    end else if (idx == `TEC_IDX_ISC) begin
      decode = TEC_R_ISC;
    end else if (idx == `TEC_IDX_MODE) begin
      decode = TEC_R_MODE;
    end else if (idx == `TEC_IDX_PRESCALE) begin
      decode = TEC_R_PRESCALE;
    end else if (idx == `TEC_IDX_OUTCTL) begin
      decode = TEC_R_OUTCTL;
    end else if (idx == `TEC_IDX_CMP_A) begin
      decode = TEC_R_CMP_A;
    end else if (idx == `TEC_IDX_CMP_B) begin
      decode = TEC_R_CMP_B;
    end else if (idx == `TEC_IDX_COUNT) begin
      decode = TEC_R_COUNT;
    end else begin
      decode = TEC_R_NONE;
    end
  endfunction : decode

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  logic [`TEC_ADDR_W-1:0] awaddr_r;
  logic [31:0]            wdata_r;
  logic [3:0]             wstrb_r;
  logic                   aw_got_r;
  logic                   w_got_r;
  logic                   wr_go;
  tec_reg_t               wr_sel;

  logic [1:0]  timer_mode_reg_r;
  logic [5:0]  prescale_reg_r;
  logic [4:0]  output_ctrl_reg_r;
  logic [15:0] compare_a_r;
  logic [15:0] compare_b_r;
  logic [15:0] count_register_r;
  logic [7:0]  input_switch_ctrl_r;

  assign wr_go  = aw_got_r && w_got_r && !s_axi_bvalid;
  assign wr_sel = decode(awaddr_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= 32'h0;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TEC_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_got_r && !(s_axi_awvalid && s_axi_awready) && !wr_go;
      s_axi_wready  <= !w_got_r && !(s_axi_wvalid && s_axi_wready) && !wr_go;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_sel == TEC_R_NONE) ? `TEC_RESP_SLVERR : `TEC_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Reading the count only samples it; the counter never sees the read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `TEC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `TEC_RESP_OKAY;
        case (decode(s_axi_araddr))
          TEC_R_DIR:      s_axi_rdata <= {24'h0, port3_dir_reg};
          TEC_R_ISC:      s_axi_rdata <= {24'h0, input_switch_ctrl_r};
          TEC_R_MODE:     s_axi_rdata <= {28'h0, timer_mode_reg_r, 2'h0};
          TEC_R_PRESCALE: s_axi_rdata <= {26'h0, prescale_reg_r};
          TEC_R_OUTCTL:   s_axi_rdata <= {27'h0, output_ctrl_reg_r};
          TEC_R_CMP_A:    s_axi_rdata <= {16'h0, compare_a_r};
          TEC_R_CMP_B:    s_axi_rdata <= {16'h0, compare_b_r};
          TEC_R_COUNT:    s_axi_rdata <= {16'h0, count_register_r};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `TEC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  logic wr_lo;
  logic wr_hi;
  logic lvl_set_pulse;
  logic lvl_clr_pulse;

  assign wr_lo = wr_go && wstrb_r[0];
  assign wr_hi = wr_go && wstrb_r[1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_mode_reg_r    <= `TEC_MODE_STOP;
      prescale_reg_r      <= 6'h00;
      output_ctrl_reg_r   <= 5'h00;
      compare_a_r         <= `TEC_RST_CMP;
      compare_b_r         <= `TEC_RST_CMP;
      input_switch_ctrl_r <= `TEC_RST_ISC;
      port3_dir_reg       <= `TEC_RST_PORT3_DIR;
      lvl_set_pulse       <= 1'b0;
      lvl_clr_pulse       <= 1'b0;
    end else begin
      lvl_set_pulse <= 1'b0;
      lvl_clr_pulse <= 1'b0;
      if (wr_lo) begin
        case (wr_sel)
          TEC_R_DIR:      port3_dir_reg <= wdata_r[7:0] | `TEC_DIR_FIXED;
          TEC_R_ISC:      input_switch_ctrl_r <= wdata_r[7:0] & `TEC_ISC_MASK;
          TEC_R_MODE:     timer_mode_reg_r <= wdata_r[3:2];
          TEC_R_PRESCALE: prescale_reg_r <= wdata_r[5:0];
          TEC_R_OUTCTL: begin
            // Level bits are triggers and read back as zero
            output_ctrl_reg_r <= {wdata_r[`TEC_OC_TOGGLE_B], 2'h0, wdata_r[1:0]};
            lvl_set_pulse     <= wdata_r[`TEC_OC_LVL_SET] && !wdata_r[`TEC_OC_LVL_CLR];
            lvl_clr_pulse     <= wdata_r[`TEC_OC_LVL_CLR] && !wdata_r[`TEC_OC_LVL_SET];
          end
          TEC_R_CMP_A:    compare_a_r[7:0] <= wdata_r[7:0];
          TEC_R_CMP_B:    compare_b_r[7:0] <= wdata_r[7:0];
          default: ;
        endcase
      end
      if (wr_hi && wr_sel == TEC_R_CMP_A) begin
        compare_a_r[15:8] <= wdata_r[15:8];
      end
      if (wr_hi && wr_sel == TEC_R_CMP_B) begin
        compare_b_r[15:8] <= wdata_r[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input routing

  logic serial_rx;
  logic event_input;

  always_comb begin
    case (input_switch_ctrl_r[`TEC_ISC_PIN_HI:`TEC_ISC_PIN_LO])
      2'h0:    serial_rx = pins_in.port11_bit3 && input_switch_ctrl_r[`TEC_ISC_RX11_EN];
      2'h2:    serial_rx = pins_in.port1_bit2;
      default: serial_rx = 1'b1;
    endcase
  end

  assign event_input = input_switch_ctrl_r[`TEC_ISC_EVT_SEL] ? serial_rx : pins_in.port3_bit3;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route_out <= '0;
    end else begin
      route_out.ext_interrupt0 <= input_switch_ctrl_r[`TEC_ISC_EXT0_SEL] ? serial_rx
                                                                        : pins_in.pin_ext_interrupt0;
      route_out.aux_timer_input <= input_switch_ctrl_r[`TEC_ISC_AUX_GATE]
                                   ? (pins_in.port3_bit4 && pins_in.aux_pwm_output)
                                   : pins_in.port3_bit4;
      route_out.port11_bit2 <= (input_switch_ctrl_r[`TEC_ISC_PIN_HI:`TEC_ISC_PIN_LO] == 2'h0)
                               ? pins_in.serial6_transmit : 1'b1;
      route_out.port1_bit3  <= (input_switch_ctrl_r[`TEC_ISC_PIN_HI:`TEC_ISC_PIN_LO] == 2'h2)
                               ? pins_in.serial6_transmit : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter

  logic running;
  logic event_mode;
  logic presc_tick;
  logic edge_pulse;
  logic count_tick;
  logic first_edge_r;
  logic hit_a;
  logic hit_b;
  logic wave_r;

  assign running    = (timer_mode_reg_r == `TEC_MODE_RUN);
  assign event_mode = (prescale_reg_r[1:0] == `TEC_CLK_EVENT);

  tec_prescaler #(.DIV_W(2)) u_presc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (!running),
    .sel     (prescale_reg_r[1:0]),
    .tick    (presc_tick)
  );

  tec_edge_filter u_edge (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .din        (event_input),
    .edge_sel   (prescale_reg_r[`TEC_PS_EDGE_HI:`TEC_PS_EDGE_LO]),
    .edge_pulse (edge_pulse)
  );

  // In event mode the first edge only arms the counter: first match after M+2 edges
  assign count_tick = running && (event_mode ? (edge_pulse && !first_edge_r) : presc_tick);
  assign hit_a      = count_tick && (count_register_r == compare_a_r);
  assign hit_b      = count_tick && (count_register_r == compare_b_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_edge_r <= 1'b1;
    end else if (!running) begin
      first_edge_r <= 1'b1;
    end else if (event_mode && edge_pulse) begin
      first_edge_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_register_r <= 16'h0000;
    end else if (!running) begin
      count_register_r <= 16'h0000;
    end else if (hit_a) begin
      count_register_r <= 16'h0000;
    end else if (count_tick) begin
      count_register_r <= count_register_r + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_a_irq <= 1'b0;
      match_b_irq <= 1'b0;
    end else begin
      match_a_irq <= hit_a;
      match_b_irq <= hit_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wave output and pin drive

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_r <= 1'b0;
    end else if (lvl_set_pulse) begin
      wave_r <= 1'b1;
    end else if (lvl_clr_pulse) begin
      wave_r <= 1'b0;
    end else if ((hit_a && output_ctrl_reg_r[`TEC_OC_TOGGLE_A]) ||
                 (hit_b && output_ctrl_reg_r[`TEC_OC_TOGGLE_B])) begin
      wave_r <= !wave_r;
    end
  end

  // Disabled output sits low; software also owns the direction bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_output   <= 1'b0;
      port3_bit4_oe <= 1'b0;
    end else begin
      wave_output   <= wave_r && output_ctrl_reg_r[`TEC_OC_ENABLE];
      port3_bit4_oe <= !port3_dir_reg[4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_match_a;
    hit_a;
  endsequence

  sequence s_cleared_and_irq;
    (count_register_r == 16'h0000) && match_a_irq;
  endsequence

  a_match_a_clear: assert property (s_match_a |=> s_cleared_and_irq)
    else $error("Compare A match did not clear count and raise irq");

  a_count_step: assert property (count_tick && !hit_a
                                 |=> count_register_r == $past(count_register_r) + 16'h0001)
    else $error("Count did not advance by one");

  a_count_hold: assert property (running && !count_tick |=> count_register_r == $past(count_register_r))
    else $error("Count moved without a tick");

  a_stop_zero: assert property (!running |=> count_register_r == 16'h0000)
    else $error("Stopped counter not zero");

  a_match_b_irq: assert property (hit_b |=> match_b_irq)
    else $error("Compare B match without irq");

  a_wave_toggle: assert property (hit_a && output_ctrl_reg_r[1] && !hit_b && !lvl_set_pulse && !lvl_clr_pulse
                                  |=> wave_r != $past(wave_r))
    else $error("Wave did not toggle on compare A");

  a_first_edge: assert property (running && event_mode && first_edge_r && edge_pulse
                                 |=> count_register_r == 16'h0000 && !first_edge_r)
    else $error("First event edge was counted");

  a_isc_top_zero: assert property (input_switch_ctrl_r[7:6] == 2'h0)
    else $error("Switch register top bits not zero");

  a_dir_fixed: assert property ((port3_dir_reg & `TEC_DIR_FIXED) == `TEC_DIR_FIXED)
    else $error("Fixed direction bits not one");

  // Checked against the pins themselves, not against the receive mux
  a_event_route: assert property (event_input ==
                                  (!input_switch_ctrl_r[`TEC_ISC_EVT_SEL] ? pins_in.port3_bit3 :
                                   input_switch_ctrl_r[5:4] == 2'h2 ? pins_in.port1_bit2 :
                                   input_switch_ctrl_r[5:4] == 2'h0 ? pins_in.port11_bit3 && input_switch_ctrl_r[3] :
                                   1'b1))
    else $error("Event input routed from wrong source");

  a_ext0_route: assert property (1'b1 |=> route_out.ext_interrupt0 ==
                                 ($past(input_switch_ctrl_r[0]) ? $past(serial_rx) : $past(pins_in.pin_ext_interrupt0)))
    else $error("Interrupt 0 routed from wrong source");

endmodule : tec_timer16

//--- tec_evt_src.sv
// Event source and pin model facing the timer
`timescale 1ns/1ps
module tec_evt_src
  import tec_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         gen_en,
  input  wire logic         glitch,
  input  wire tec_pins_in_t pins_tb,
  output tec_pins_in_t      pins_out,
  output logic              ev_tick
);
  logic [1:0] ph_r;
  logic       lvl_r;
  logic       gl_r;
  // Level held four clocks, well over the filter span
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph_r    <= 2'h0;
      lvl_r   <= 1'b0;
      gl_r    <= 1'b0;
      ev_tick <= 1'b0;
    end else begin
      ph_r    <= gen_en ? ph_r + 2'h1 : 2'h0;
      ev_tick <= gen_en && ph_r == 2'h3;
      lvl_r   <= lvl_r ^ (gen_en && ph_r == 2'h3);
      // One-clock spike mid-level, must be rejected
      gl_r    <= glitch && ph_r == 2'h1;
    end
  end
  always_comb begin
    pins_out            = pins_tb;
    pins_out.port3_bit3 = lvl_r ^ gl_r;
  end
endmodule : tec_evt_src

//--- test_tec_timer16.sv
// Self-checking bench of the timer and event counter
`timescale 1ns/1ps
`include "tec_cfg.svh"
module test_tec_timer16
  import tec_pkg::*;
;
  typedef struct packed {
    logic [15:0] idx;
    logic [31:0] wd;
    logic [31:0] rd;
    logic [1:0]  rs;
  } tec_row_t;
  logic           aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic           arvalid, arready, rvalid, rready, irq_a, irq_b, wave, oe, gen_en, glitch, ev_tick;
  logic [17:0]    awaddr, araddr;
  logic [31:0]    wdata, rdata, rv;
  logic [3:0]     wstrb;
  logic [1:0]     bresp, rresp, rs;
  logic [7:0]     dir;
  logic           w0;
  tec_pins_in_t   pins_tb, pins;
  tec_route_out_t route;
  int             n_fail = 0, compares = 0, gap = 0, a_gap = 0, ev_cnt = 0, ev_gap = 0;
  int             n_a = 0, n_b = 0, a0, b0;
  // Unmapped index last; count register is read-only
  tec_row_t rows [7] = '{
    '{`TEC_IDX_ISC, 32'h000000FF, 32'h0000003F, `TEC_RESP_OKAY},
    '{`TEC_IDX_ISC, 32'h00000000, 32'h00000000, `TEC_RESP_OKAY},
    '{`TEC_IDX_PORT3_DIR, 32'h00000000, 32'h000000E1, `TEC_RESP_OKAY},
    '{`TEC_IDX_PORT3_DIR, 32'h000000FF, 32'h000000FF, `TEC_RESP_OKAY},
    '{`TEC_IDX_CMP_B, 32'h00001234, 32'h00001234, `TEC_RESP_OKAY},
    '{`TEC_IDX_COUNT, 32'h00000055, 32'h00000000, `TEC_RESP_OKAY},
    '{16'h0010, 32'h00000055, 32'h00000000, `TEC_RESP_SLVERR}};
  // Switch value, pins, expected routing
  logic [18:0] rts [5] = '{{8'h00, 7'h24, 4'h7}, {8'h0F, 7'h31, 4'hE}, {8'h07, 7'h32, 4'h5},
                           {8'h23, 7'h08, 4'hA}, {8'h11, 7'h00, 4'hE}};

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  tec_evt_src u_src (.aclk(aclk), .aresetn(aresetn), .gen_en(gen_en), .glitch(glitch),
                     .pins_tb(pins_tb), .pins_out(pins), .ev_tick(ev_tick));

  tec_timer16 DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pins_in(pins),
    .route_out(route), .match_a_irq(irq_a), .match_b_irq(irq_b), .wave_output(wave),
    .port3_bit4_oe(oe), .port3_dir_reg(dir));

  // Cycle and edge tallies between compare A pulses
  always @(posedge aclk) begin
    gap    <= irq_a ? 1 : gap + 1;
    ev_cnt <= irq_a ? 0 : ev_cnt + ev_tick;
    n_a    <= n_a + irq_a;
    n_b    <= n_b + irq_b;
    if (irq_a) begin
      a_gap  <= gap;
      ev_gap <= ev_cnt;
    end
  end

  ////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task wr(input logic [15:0] idx, input logic [31:0] d);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs     = bresp;
        bready <= 1'b0;
        done   = 1'b1;
      end
    end
  endtask : wr

  task rd(input logic [15:0] idx);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rv     = rdata;
        rs     = rresp;
        rready <= 1'b0;
        done   = 1'b1;
      end
    end
  endtask : rd

  // Bounded wait for one compare A pulse; running out counts as a mismatch
  task wait_a();
    logic got;
    got = 1'b0;
    for (int i = 0; i < 2000 && !got; i++) begin
      @(posedge aclk);
      got = (irq_a === 1'b1);
    end
    #1;
    chk("irq_a_seen", 32'(got), 32'h1);
  endtask : wait_a

  task give_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    n_fail++;
    give_verdict();
  end

  initial begin
    aresetn = 1'b0;
    awaddr  = '0;
    araddr  = '0;
    wdata   = '0;
    wstrb   = 4'h0;
    awvalid = 1'b0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    arvalid = 1'b0;
    rready  = 1'b0;
    pins_tb = '0;
    gen_en  = 1'b0;
    glitch  = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`TEC_IDX_PORT3_DIR);
    chk("dir_rst", rv, 32'hFF);
    rd(`TEC_IDX_ISC);
    chk("isc_rst", rv, 32'h0);
    chk("oe_rst", 32'(oe), 32'h0);
    for (int i = 0; i < 7; i++) begin
      wr(rows[i].idx, rows[i].wd);
      chk("wresp", 32'(rs), 32'(rows[i].rs));
      rd(rows[i].idx);
      chk("rdata", rv, rows[i].rd);
      chk("rresp", 32'(rs), 32'(rows[i].rs));
    end
    for (int i = 0; i < 5; i++) begin
      wr(`TEC_IDX_ISC, 32'(rts[i][18:11]));
      pins_tb <= tec_pins_in_t'(rts[i][10:4]);
      repeat (3) @(posedge aclk);
      #1 chk("route", 32'(route), 32'(rts[i][3:0]));
    end
    // Interval timer with square wave, clock every cycle
    wr(`TEC_IDX_PRESCALE, 32'h0);
    wr(`TEC_IDX_CMP_A, 32'h5);
    wr(`TEC_IDX_CMP_B, 32'h2);
    wr(`TEC_IDX_OUTCTL, 32'h3);
    wr(`TEC_IDX_PORT3_DIR, 32'hEF);
    #1 chk("oe_out", 32'({oe, dir}), 32'h1EF);
    wr(`TEC_IDX_MODE, 32'hC);
    wait_a();
    a0 = n_a;
    b0 = n_b;
    w0 = wave;
    wait_a();
    chk("wave_tgl", 32'(wave), 32'(!w0));
    rd(`TEC_IDX_COUNT);
    chk("cnt_rng", 32'(rv <= 32'h5), 32'h1);
    wait_a();
    chk("a_gap", 32'(a_gap), 32'h6);
    chk("b_per_a", 32'(n_b - b0), 32'(n_a - a0));
    wr(`TEC_IDX_OUTCTL, 32'h1);
    wait_a();
    w0 = wave;
    wait_a();
    wait_a();
    chk("wave_hold", 32'(wave), 32'(w0));
    wr(`TEC_IDX_MODE, 32'h0);
    rd(`TEC_IDX_COUNT);
    chk("cnt_stop", rv, 32'h0);
    // Count clock every fourth cycle: interval grows fourfold
    wr(`TEC_IDX_PRESCALE, 32'h2);
    wr(`TEC_IDX_MODE, 32'hC);
    wait_a();
    wait_a();
    chk("a_gap_div4", 32'(a_gap), 32'h18);
    wr(`TEC_IDX_MODE, 32'h0);
    // Event counting on both edges; the stray spike must not count
    wr(`TEC_IDX_PORT3_DIR, 32'hFF);
    wr(`TEC_IDX_ISC, 32'h0);
    wr(`TEC_IDX_PRESCALE, 32'h33);
    wr(`TEC_IDX_CMP_A, 32'h3);
    wr(`TEC_IDX_MODE, 32'hC);
    gen_en <= 1'b1;
    wait_a();
    chk("ev_first", 32'(ev_gap), 32'h5);
    @(posedge aclk);
    glitch <= 1'b1;
    wait_a();
    chk("ev_next", 32'(ev_gap), 32'h4);
    // Reset in mid-run while events are counted
    @(posedge aclk);
    gen_en  <= 1'b0;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`TEC_IDX_MODE);
    chk("mode_rst", rv, 32'h0);
    rd(`TEC_IDX_COUNT);
    chk("cnt_rst", rv, 32'h0);
    chk("out_rst", 32'({wave, irq_a, oe}), 32'h0);
    give_verdict();
  end
endmodule : test_tec_timer16
